// ===== rtl/duty_slicer.sv
// sub-slot duty generator for one digit time slot
// assumes sub_idx steps 0..15 within every digit slot
`timescale 1ns/1ps
module duty_slicer (
  input  wire logic [3:0] code,
  input  wire logic [3:0] sub_idx,
  output logic            on
);
  logic [3:0] eff;
  always_comb begin
    // code 15 behaves like 14: 15/16 is the ceiling
    eff = (code > led_cfg_pkg::duty_max_code) ? led_cfg_pkg::duty_max_code
                                                : code;
    on  = (sub_idx <= eff);
  end
endmodule // duty_slicer

// ===== rtl/led_cfg_pkg.sv
// constants and carrier types for the led display config/intensity block
// assumes the serial engine outside presents decoded register accesses
package led_cfg_pkg;
  localparam logic [7:0] global_duty_level_addr = 8'h02;
  localparam logic [7:0] digit_scan_count_addr  = 8'h03;
  localparam logic [7:0] control_flags_addr     = 8'h04;
  localparam logic [7:0] digit_pair_duty_addr   = 8'h10;
  localparam logic [7:0] digit_pair_duty_last   = 8'h13;
  localparam logic [7:0] control_flags_reset    = 8'h00;
  localparam logic [7:0] global_duty_reset      = 8'h00;
  localparam logic [7:0] scan_count_reset       = 8'h07;
  localparam int         run_bit                = 0;
  localparam int         rate_bit               = 2;
  localparam int         blink_en_bit           = 3;
  localparam int         sync_bit               = 4;
  localparam int         clear_bit              = 5;
  localparam int         duty_sel_bit           = 6;
  localparam int         phase_bit              = 7;
  localparam int         num_digits             = 8;
  localparam int         sub_slots              = 16;
  localparam logic [3:0] duty_max_code          = 4'he;
  // cycles per sub-slot; shortened by parameter in the top for simulation
  localparam int         sub_slot_cycles        = 256;
  localparam int         slow_half_ms           = 1000;
  localparam int         fast_half_ms           = 500;
  localparam int         clk_mhz                = 250;
  localparam longint     slow_half_cycles = longint'(slow_half_ms) * 1000 *
                                            clk_mhz;
  localparam longint     fast_half_cycles = longint'(fast_half_ms) * 1000 *
                                            clk_mhz;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       ack;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] segs;
    logic [2:0] digit;
    logic       lit;
  } scan_out_type;
endpackage

// ===== rtl/led_display_config_intensity.sv
// multiplex, blink and intensity control of the led display driver
// assumes the serial engine gives one-cycle wr/rd strokes and ack
// marks the acknowledge bit of the data byte being written
//
// Overview of operation
// - blink sync bit zero leaves the blink counters running
// - blink sync bit one resets blink counters at the write acknowledge
// - clear bit zero keeps both digit planes unchanged
// - clear bit one clears both planes during the write acknowledge
// - duty select zero uses the global intensity for every digit
// - duty select one uses each digit's own intensity nibble
// - reading control flags returns blink phase in bit seven
// - scan digits zero to N, N from low three scan bits
// - global code n gives (n+1)/16, code fifteen like fourteen
// - blink enable turns blinking on; rate bit picks slow or fast
// - differing plane bits light a segment in one blink half only
// - lowest control bit zero means shutdown, one means running
`timescale 1ns/1ps
module led_display_config_intensity #(
  parameter int sub_cycles = led_cfg_pkg::sub_slot_cycles,
  parameter longint slow_half = led_cfg_pkg::slow_half_cycles,
  parameter longint fast_half = led_cfg_pkg::fast_half_cycles
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire led_cfg_pkg::reg_req_type  req,
  input  wire logic [2:0]                plane_digit,
  input  wire logic                      plane_sel,
  input  wire logic                      plane_wr,
  input  wire logic [7:0]                plane_wdata,
  output logic [7:0]                     rdata,
  output led_cfg_pkg::scan_out_type      scan
);
  logic [7:0]  ctrl_q;
  logic [7:0]  gduty_q;
  logic [7:0]  scan_q;
  logic [7:0]  pair_q [4];
  logic [7:0]  first_plane_q  [led_cfg_pkg::num_digits];
  logic [7:0]  second_plane_q [led_cfg_pkg::num_digits];
  logic        ctrl_wr_pend_q;
  logic [7:0]  ctrl_wr_data_q;
  logic        sync_pulse;
  logic        clear_pulse;
  logic [31:0] blink_cnt_q;
  logic        phase_q;
  logic [15:0] sub_cnt_q;
  logic [3:0]  sub_idx_q;
  logic [2:0]  digit_q;
  logic [3:0]  duty_code;
  logic        duty_on;
  logic [7:0]  seg_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q  <= led_cfg_pkg::control_flags_reset;
      gduty_q <= led_cfg_pkg::global_duty_reset;
      scan_q  <= led_cfg_pkg::scan_count_reset;
      for (int i = 0; i < 4; i++) begin
        pair_q[i] <= 8'h00;
      end
    end else if (req.wr) begin
      if (hit(req.addr, led_cfg_pkg::global_duty_level_addr)) begin
        gduty_q <= req.wdata;
      end else if (hit(req.addr, led_cfg_pkg::digit_scan_count_addr)) begin
        scan_q <= req.wdata;
      end else if (hit(req.addr, led_cfg_pkg::control_flags_addr)) begin
        ctrl_q <= req.wdata;
      end else if (req.addr >= led_cfg_pkg::digit_pair_duty_addr &&
                   req.addr <= led_cfg_pkg::digit_pair_duty_last) begin
        pair_q[req.addr[1:0]] <= req.wdata;
      end
    end
  end

  // one-shot actions held until the acknowledge bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_wr_pend_q <= 1'b0;
      ctrl_wr_data_q <= 8'h00;
    end else if (req.wr && hit(req.addr, led_cfg_pkg::control_flags_addr))
    begin
      ctrl_wr_pend_q <= 1'b1;
      ctrl_wr_data_q <= req.wdata;
    end else if (req.ack) begin
      ctrl_wr_pend_q <= 1'b0;
    end
  end

  always_comb begin
    sync_pulse  = ctrl_wr_pend_q && req.ack &&
                  ctrl_wr_data_q[led_cfg_pkg::sync_bit];
    clear_pulse = ctrl_wr_pend_q && req.ack &&
                  ctrl_wr_data_q[led_cfg_pkg::clear_bit];
  end

  // ----------------------------------------------------------------
  // digit planes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || clear_pulse) begin
      for (int i = 0; i < led_cfg_pkg::num_digits; i++) begin
        first_plane_q[i]  <= 8'h00;
        second_plane_q[i] <= 8'h00;
      end
    end else if (plane_wr) begin
      if (plane_sel) begin
        second_plane_q[plane_digit] <= plane_wdata;
      end else begin
        first_plane_q[plane_digit] <= plane_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // blink timing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || sync_pulse) begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q     <= 1'b1;
    end else if (blink_cnt_q >= 32'((ctrl_q[led_cfg_pkg::rate_bit] ?
                 fast_half : slow_half) - 1)) begin
      blink_cnt_q <= 32'h0000_0000;
      phase_q     <= ~phase_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // multiplex scan
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sub_cnt_q <= 16'h0000;
      sub_idx_q <= 4'h0;
      digit_q   <= 3'h0;
    end else if (sub_cnt_q == 16'(sub_cycles - 1)) begin
      sub_cnt_q <= 16'h0000;
      sub_idx_q <= sub_idx_q + 4'h1;
      if (sub_idx_q == 4'hf) begin
        // wrap at the scan limit; upper bits ignored
        digit_q <= (digit_q >= scan_q[2:0]) ? 3'h0 : digit_q + 3'h1;
      end
    end else begin
      sub_cnt_q <= sub_cnt_q + 16'h0001;
    end
  end

  always_comb begin
    logic [7:0] pr;
    pr = pair_q[digit_q[2:1]];
    if (ctrl_q[led_cfg_pkg::duty_sel_bit]) begin
      duty_code = digit_q[0] ? pr[7:4] : pr[3:0];
    end else begin
      duty_code = gduty_q[3:0];
    end
  end

  duty_slicer u_slicer (
    .code    (duty_code),
    .sub_idx (sub_idx_q),
    .on      (duty_on)
  );

  always_comb begin
    if (ctrl_q[led_cfg_pkg::blink_en_bit]) begin
      // phase one shows the first plane half
      seg_d = phase_q ? first_plane_q[digit_q]
                      : second_plane_q[digit_q];
    end else begin
      seg_d = first_plane_q[digit_q];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scan <= '0;
    end else begin
      scan.digit <= digit_q;
      scan.lit   <= ctrl_q[led_cfg_pkg::run_bit] && duty_on;
      scan.segs  <= ctrl_q[led_cfg_pkg::run_bit] ? seg_d : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      if (hit(req.addr, led_cfg_pkg::control_flags_addr)) begin
        rdata <= {phase_q, ctrl_q[6:0]};
      end else if (hit(req.addr, led_cfg_pkg::global_duty_level_addr)) begin
        rdata <= gduty_q;
      end else if (hit(req.addr, led_cfg_pkg::digit_scan_count_addr)) begin
        rdata <= scan_q;
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  clear_planes_a: assert property (@(posedge sys_clk) disable iff (rst)
    clear_pulse |=> first_plane_q[0] == 8'h00 && second_plane_q[7] == 8'h00)
    else $error("planes not cleared");
  sync_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    sync_pulse |=> blink_cnt_q == 32'h0 && phase_q)
    else $error("blink not resynced");
  // counter must either step or wrap with a phase flip, never restart
  no_sync_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ctrl_wr_pend_q && req.ack && !ctrl_wr_data_q[led_cfg_pkg::sync_bit])
    |=> (blink_cnt_q == $past(blink_cnt_q) + 32'h0000_0001) ||
        (blink_cnt_q == 32'h0000_0000 && phase_q != $past(phase_q)))
    else $error("spurious sync");
  once_only_a: assert property (@(posedge sys_clk) disable iff (rst)
    clear_pulse |=> !clear_pulse) else $error("clear repeated");
  phase_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (req.rd && hit(req.addr, led_cfg_pkg::control_flags_addr))
    |=> rdata[7] == $past(phase_q)) else $error("bad phase");
  scan_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(digit_q) |-> digit_q <= scan_q[2:0] || digit_q == 3'h0)
    else $error("digit past limit");
  shutdown_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_q[led_cfg_pkg::run_bit] |=> !scan.lit)
    else $error("lit in shutdown");
  duty_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
    sub_idx_q == 4'hf |-> !duty_on) else $error("duty over 15/16");
  global_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_q[led_cfg_pkg::duty_sel_bit] |->
    duty_on == (sub_idx_q <= gduty_q[3:0] && sub_idx_q != 4'hf))
    else $error("wrong duty source");
  clear_cov_c: cover property (@(posedge sys_clk) clear_pulse);
  sync_cov_c:  cover property (@(posedge sys_clk) sync_pulse);
  phase_cov_c: cover property (@(posedge sys_clk) $changed(phase_q));
endmodule // led_display_config_intensity

// ===== tb/host_model.sv
// host side model: register writes and reads on the request port
// assumes the caller shares the device clock; every write is acked
`timescale 1ns/1ps
module host_model (
  input  wire logic                sys_clk,
  input  wire logic [7:0]          rdata,
  output led_cfg_pkg::reg_req_type req
);
  initial req = '0;

  // ack follows the data byte, as the serial engine would give it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    req.ack <= 1'b1;
    @(posedge sys_clk);
    req.ack <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // host_model

// ===== tb/led_display_config_intensity_tb.sv
// self-checking bench of the led config and intensity block
// assumes short sub-slot and blink parameters set at the instance
`timescale 1ns/1ps
module led_display_config_intensity_tb;
  logic                      sys_clk, rst, plane_sel, plane_wr;
  logic [2:0]                plane_digit;
  logic [7:0]                plane_wdata, rdata, d;
  logic [15:0]               c, s;
  led_cfg_pkg::reg_req_type  req;
  led_cfg_pkg::scan_out_type scan;
  int                        mismatches, compares;
  logic [7:0] codes [4] = '{8'h00, 8'hf3, 8'h0e, 8'h0f};

  led_display_config_intensity #(.sub_cycles(2), .slow_half(20),
    .fast_half(10)) DUT (.sys_clk(sys_clk), .rst(rst), .req(req),
    .plane_digit(plane_digit), .plane_sel(plane_sel),
    .plane_wr(plane_wr), .plane_wdata(plane_wdata), .rdata(rdata),
    .scan(scan));
  host_model host (.sys_clk(sys_clk), .rdata(rdata), .req(req));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, exp, input string m);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m,
               seen, exp);
    end
  endtask

  task end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic pw(input logic sel, input logic [2:0] dg,
                    input logic [7:0] v);
    @(posedge sys_clk);
    plane_wr <= 1'b1;
    plane_sel <= sel;
    plane_digit <= dg;
    plane_wdata <= v;
    @(posedge sys_clk);
    plane_wr <= 1'b0;
  endtask

  // c: lit cycles of digit dg, s: cycles of dg with segments set
  // 640 cycles is a whole number of scan rounds for limits 0 and 1
  task automatic tally(input logic [2:0] dg);
    c = '0;
    s = '0;
    repeat (64) @(posedge sys_clk);
    repeat (640) begin
      @(posedge sys_clk) #1;
      if (scan.digit === dg && scan.lit === 1'b1) c++;
      if (scan.digit === dg && scan.segs !== 8'h00) s++;
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    host.rd(8'h02, d);
    check(d, 8'h00, "global duty reset");
    host.rd(8'h03, d);
    check(d, 8'h07, "scan count reset");
    host.rd(8'h04, d);
    check(d[6:0], 7'h00, "control reset");
    host.rd(8'h05, d);
    check(d, 8'h00, "unmapped read");
  endtask

  task automatic t_global_duty;
    pw(1'b0, 3'h0, 8'hff);
    pw(1'b0, 3'h1, 8'hff);
    host.wr(8'h03, 8'h00);
    host.wr(8'h04, 8'h01);
    foreach (codes[i]) begin
      host.wr(8'h02, codes[i]);
      tally(3'h0);
      check(c, 16'((codes[i][3:0] == 4'hf ? 15 : codes[i][3:0] + 1)
            * 40), "global duty");
    end
    host.wr(8'h04, 8'h00);
    tally(3'h0);
    check(c, 16'h0, "shutdown dark");
  endtask

  task automatic t_digit_duty;
    host.wr(8'h03, 8'h01);
    host.wr(8'h10, 8'h52);
    host.wr(8'h04, 8'h41);
    tally(3'h0);
    check(c, 16'd60, "digit0 own duty");
    tally(3'h1);
    check(c, 16'd120, "digit1 own duty");
  endtask

  task automatic t_scan_limit;
    host.wr(8'h03, 8'hf9);
    host.wr(8'h02, 8'h0f);
    host.wr(8'h04, 8'h01);
    tally(3'h1);
    check(c, 16'd300, "digit1 in scan");
    tally(3'h2);
    check(c, 16'h0, "digit2 beyond limit");
  endtask

  task automatic t_clear;
    host.wr(8'h04, 8'h01);
    tally(3'h0);
    check(16'(s != 0), 16'h1, "data kept");
    host.wr(8'h04, 8'h21);
    tally(3'h0);
    check(s, 16'h0, "planes cleared");
    pw(1'b0, 3'h0, 8'hff);
    tally(3'h0);
    check(16'(s != 0), 16'h1, "clear not repeated");
  endtask

  // reads are placed one to six cycles after the last phase flip or resync
  task automatic t_blink;
    host.wr(8'h04, 8'h19);
    host.rd(8'h04, d);
    check(d[7], 1'b1, "phase after sync");
    repeat (20) @(posedge sys_clk);
    host.rd(8'h04, d);
    check(d[7], 1'b0, "second half");
    repeat (20) @(posedge sys_clk);
    host.rd(8'h04, d);
    check(d[7], 1'b1, "slow period");
    host.wr(8'h04, 8'h09);
    repeat (10) @(posedge sys_clk);
    host.rd(8'h04, d);
    check(d[7], 1'b0, "no resync");
    host.wr(8'h04, 8'h1d);
    repeat (10) @(posedge sys_clk);
    host.rd(8'h04, d);
    check(d[7], 1'b0, "fast half");
  endtask

  // planes differ on purpose: 3c in the first half, 5a in the second
  task automatic t_blink_segs;
    host.wr(8'h03, 8'h00);
    repeat (40) @(posedge sys_clk);
    pw(1'b0, 3'h0, 8'h3c);
    pw(1'b1, 3'h0, 8'h5a);
    host.wr(8'h04, 8'h19);
    repeat (5) @(posedge sys_clk);
    #1;
    check(scan.segs, 8'h3c, "first plane half");
    repeat (20) @(posedge sys_clk);
    #1;
    check(scan.segs, 8'h5a, "second plane half");
    host.wr(8'h04, 8'h01);
    repeat (5) @(posedge sys_clk);
    #1;
    check(scan.segs, 8'h3c, "blink off first plane");
  endtask

  initial begin
    mismatches = 0;
    compares = 0;
    rst = 1'b1;
    plane_sel = 1'b0;
    plane_wr = 1'b0;
    plane_digit = 3'h0;
    plane_wdata = 8'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_global_duty();
    t_digit_duty();
    t_scan_limit();
    t_clear();
    t_blink();
    t_blink_segs();
    end_sim();
  end

  // about nine thousand cycles expected; over four times that is a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end
endmodule // led_display_config_intensity_tb
